/* File: reset_release_sequencer_test.sv */
// Self-checking bench for the reset release sequencer
`default_nettype none

module reset_release_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] src = 6'h00;
   logic use_pll = 1'b0;
   logic sel, tick, ext_n, comb_n, wd_n, cg_n, per_n, core_n, tap_n, div, en3x, done;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int t[7];

   // Master clock never stops, not even in reset
   always #2 clk = ~clk;

   rrs_clk_partner partner (.i_sys_clk(clk), .i_rst_n(rst_n), .i_use_pll(use_pll),
      .o_clock_source_select(sel), .o_pll_2x_tick(tick));

   rrs_top uut (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_partial_powerdown_recovery(src[5]), .i_external_pin_reset_n(~src[4]),
      .i_watchdog_core_reset(src[0]), .i_watchdog_lost_reference_reset(src[1]),
      .i_low_voltage_reset(src[2]), .i_software_reset(src[3]),
      .i_clock_source_select(sel), .i_pll_2x_tick(tick),
      .o_extended_por_rst_n(ext_n), .o_combined_rst_n(comb_n),
      .o_watchdog_logic_rst_n(wd_n), .o_clkgen_rst_n(cg_n), .o_perip_rst_n(per_n),
      .o_core_rst_n(core_n), .o_test_access_rst_n(tap_n), .o_sys_clk_div(div),
      .o_clk3x_enable(en3x), .o_startup_done(done));

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string name, input int exp, input int seen, input int tol);
      n_compared++;
      if (seen < exp - tol || seen > exp + tol)
      begin
         err_count++;
         $display("wrong value %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic seen);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask

   // Cycle of first high level of each staged output after a release
   task automatic expect_seq(input int c0, input logic pwr);
      logic [6:0] v;
      t = '{default: -1};
      for (int c = 0; c <= 400; c++)
      begin
         if (c > 0)
            @(posedge clk);
         #0.5;
         v = {done, core_n, per_n, cg_n, wd_n, comb_n, ext_n};
         for (int k = 0; k < 7; k++)
            if (v[k] === 1'b1 && t[k] < 0)
               t[k] = c;
      end
      if (pwr)
         chk("extended_por", c0, t[0], 0);
      chk("combined", c0, t[1], 0);
      chk("watchdog_logic", c0 + 3, t[2], 0);
      chk("clkgen", c0 + 32, t[3], 0);
      chk("perip", t[3] + 64, t[4], 1);
      chk("core", t[4] + 64, t[5], 1);
      chk("startup_done", t[5] + 1, t[6], 0);
   endtask

   // Divider follows PLL edges, or every master edge when master chosen
   task automatic clk_run(input logic pll);
      logic prev;
      logic tk;
      @(posedge clk);
      #1 use_pll = pll;
      @(posedge clk);
      #0.5;
      chk_bit("clk3x_enable", pll, en3x);
      for (int i = 0; i < 24; i++)
      begin
         prev = div;
         tk = pll ? tick : 1'b1;
         @(posedge clk);
         #0.5;
         chk_bit("sys_clk_div", prev ^ tk, div);
      end
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         err_count++;
         $display("wrong value timeout expected 0 seen 1");
         summarize();
      end
   end

   initial
   begin
      int s;
      int hold;
      void'($urandom(71));
      repeat (2) @(posedge clk);
      #0.5;
      chk_bit("test_access", 1'b0, tap_n);
      chk_bit("core_in_reset", 1'b0, core_n | done);
      #0.5 rst_n = 1'b1;
      expect_seq(66, 1'b1);
      chk_bit("test_access", 1'b1, tap_n);
      // Every source once in turn, then random picks with random hold
      for (int n = 0; n < 9; n++)
      begin
         s = (n < 6) ? n : $urandom % 6;
         hold = 1 + $urandom % 8;
         @(posedge clk);
         #1 src[s] = 1'b1;
         #0.5;
         chk_bit("combined_assert", 1'b0, comb_n);
         chk_bit("down_stages", 1'b0, wd_n | cg_n | per_n | core_n);
         chk_bit("extended_por", (s == 5) ? 1'b0 : 1'b1, ext_n);
         chk_bit("test_access", 1'b1, tap_n);
         repeat (hold) @(posedge clk);
         #1 src[s] = 1'b0;
         // Async sources pay the two-flop synchroniser on release
         expect_seq((s < 4) ? 0 : (s == 4) ? 2 : 66, s == 5);
      end
      clk_run(1'b1);
      clk_run(1'b0);
      summarize();
   end
endmodule

`default_nettype wire

/* File: rrs_clk_partner.sv */
// Clock synthesis stand-in: source select and PLL 2x edge pattern
`default_nettype none

module rrs_clk_partner
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Bench control
   input wire logic i_use_pll,
   // Towards the sequencer
   output logic o_clock_source_select,
   output logic o_pll_2x_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase_reg;
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         phase_reg <= 2'h0;
      else
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
   end
   assign o_clock_source_select = i_use_pll;
   // 2x edges every third master cycle; silent once master clock is chosen
   assign o_pll_2x_tick = i_use_pll && (phase_reg == 2'h2);
endmodule

`default_nettype wire

/* File: rrs_delay_stage.sv */
// Reset delay stage: asserts at once, releases after a count of ticks
`default_nettype none

module rrs_delay_stage
#(
   parameter int unsigned COUNT = 32,
   parameter int unsigned CW = $clog2(COUNT + 1)
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Stage input and time base
   input wire logic i_hold,
   input wire logic i_tick,
   // Stage output
   output logic o_rst_n
);

   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] cnt_reg;
   logic released_reg;

   wire counting = !released_reg && i_tick;
   wire count_done = counting && (cnt_reg == LAST);

   // Release lands on a clock edge; assertion needs no edge at all
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_reg <= '0;
         released_reg <= 1'b0;
      end
      else if (i_hold)
      begin
         cnt_reg <= '0;
         released_reg <= 1'b0;
      end
      else if (count_done)
         released_reg <= 1'b1;
      else if (counting)
         cnt_reg <= cnt_reg + 1'b1;
   end

   // Combinational term so a hold shows without waiting for an edge
   assign o_rst_n = released_reg & ~i_hold;

   chk_hold_asserts: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_hold |-> !o_rst_n)
      else $error("stage output released while input held");

   chk_release_count: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_rst_n) |-> ($past(cnt_reg) == LAST && $past(i_tick) && !$past(i_hold)))
      else $error("stage released before its count completed");

endmodule

`default_nettype wire

/* File: rrs_top.sv */
// Reset release sequencer: shared constants and the top-level sequencer
// Overview of operation
// - Partial power-down recovery reset enters asynchronously, with no clock relationship.
// - Watchdog core, lost-reference, low-voltage and software resets are synchronous sources.
// - Only power-on and recovery assert stretched reset; it releases 64 oscillator cycles later.
// - Every source asserts clock-generator reset; releases 32 oscillator cycles after all.
// - Every source asserts peripheral reset; releases 32 system cycles after clock-generator.
// - Every source asserts core reset; releases 32 system cycles after peripheral reset.
// - Test-access logic is held in reset by the power-on path only.
// - Delay stages assert at once and release after counting their cycles.
// - Power-on delay stages count on the free-running oscillator clock.
// - Resets may assert asynchronously; all but combined reset, which follows the synchronous sources, release on a rising system clock edge.
// - Combined reset is stretched reset OR all others; it holds all but extender and test access.
// - Combined reset release enables control register, sync generator and clock-generator extender.
// - Watchdog and software-reset logic reset releases three oscillator cycles after combined.
// - The master clock used for reset generation keeps running during every reset.
// - Clock-generator release enables clock generation and the peripheral reset extender.
// - Core reset release lets the processor run and marks startup complete.
// - Normal-rate system clocks come from the 2x master clock divided by two.
// - With master clock selected, 3x clock is disabled and 2x equals master.
// - The sequencer raises no interrupt requests.
`default_nettype none

package rrs_pkg;
   localparam int unsigned EXT_POR_CYCLES = 64;
   localparam int unsigned CLKGEN_CYCLES = 32;
   localparam int unsigned PERIP_SYS_CYCLES = 32;
   localparam int unsigned CORE_SYS_CYCLES = 32;
   localparam int unsigned SWLOGIC_CYCLES = 3;
   localparam int unsigned MON_W = 8;
   localparam logic [MON_W-1:0] MON_MAX = 8'hFF;
   localparam logic [1:0] SYNC_CLEAR = 2'h0;
   localparam logic [1:0] SYNC_SHIFT_IN = 2'h1;
   localparam logic SEL_PLL = 1'h1;
endpackage

module rrs_top
(
   // Clock and power-on reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Asynchronous reset sources
   input wire logic i_partial_powerdown_recovery,
   input wire logic i_external_pin_reset_n,
   // Synchronous reset sources
   input wire logic i_watchdog_core_reset,
   input wire logic i_watchdog_lost_reference_reset,
   input wire logic i_low_voltage_reset,
   input wire logic i_software_reset,
   // Clock synthesis side
   input wire logic i_clock_source_select,
   input wire logic i_pll_2x_tick,
   // Staged resets
   output logic o_extended_por_rst_n,
   output logic o_combined_rst_n,
   output logic o_watchdog_logic_rst_n,
   output logic o_clkgen_rst_n,
   output logic o_perip_rst_n,
   output logic o_core_rst_n,
   output logic o_test_access_rst_n,
   // Clock control and status
   output logic o_sys_clk_div,
   output logic o_clk3x_enable,
   output logic o_startup_done
);

   logic [1:0] por_sync_reg;
   logic [1:0] pin_sync_reg;
   logic [1:0] tap_sync_reg;
   logic sys_phase_reg;
   logic clk3x_en_reg;
   logic done_reg;
   logic [rrs_pkg::MON_W-1:0] por_rel_cnt_reg;
   logic [rrs_pkg::MON_W-1:0] comb_rel_cnt_reg;
   logic [rrs_pkg::MON_W-1:0] por_rel_cnt_next;
   logic [rrs_pkg::MON_W-1:0] comb_rel_cnt_next;

   // Recovery acts without any clock; its async clear is the assert path
   wire por_clear_n = i_rst_n & ~i_partial_powerdown_recovery;
   wire pin_clear_n = i_rst_n & i_external_pin_reset_n;
   wire por_synced_n = por_sync_reg[1];
   wire pin_synced_n = pin_sync_reg[1];
   wire sync_sources = i_watchdog_core_reset | i_watchdog_lost_reference_reset |
                       i_low_voltage_reset | i_software_reset;
   wire ext_por_n;
   wire combined_n = ext_por_n & pin_synced_n & ~sync_sources;
   wire swlogic_n;
   wire clkgen_n;
   wire perip_n;
   wire core_n;
   // Master selected: 2x equals master, so every edge is a 2x edge
   wire tick_2x = (i_clock_source_select == rrs_pkg::SEL_PLL) ? i_pll_2x_tick : 1'b1;
   wire sys_tick = tick_2x & sys_phase_reg;

   // Assert at once, release only after two edges of the oscillator
   always_ff @(posedge i_sys_clk or negedge por_clear_n)
   begin
      if (!por_clear_n)
         por_sync_reg <= rrs_pkg::SYNC_CLEAR;
      else
         por_sync_reg <= {por_sync_reg[0], 1'b1};
   end

   always_ff @(posedge i_sys_clk or negedge pin_clear_n)
   begin
      if (!pin_clear_n)
         pin_sync_reg <= rrs_pkg::SYNC_CLEAR;
      else
         pin_sync_reg <= {pin_sync_reg[0], 1'b1};
   end

   // Test access ignores recovery, pin, watchdog and software sources
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         tap_sync_reg <= rrs_pkg::SYNC_CLEAR;
      else
         tap_sync_reg <= {tap_sync_reg[0], 1'b1};
   end

   // Free-running master clock: no tick gating on the stretched, watchdog-logic and clock-generator stages
   rrs_delay_stage #(.COUNT(rrs_pkg::EXT_POR_CYCLES)) u_ext_por
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_hold(~por_synced_n),
      .i_tick(1'b1),
      .o_rst_n(ext_por_n)
   );

   rrs_delay_stage #(.COUNT(rrs_pkg::SWLOGIC_CYCLES)) u_swlogic
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_hold(~combined_n),
      .i_tick(1'b1),
      .o_rst_n(swlogic_n)
   );

   rrs_delay_stage #(.COUNT(rrs_pkg::CLKGEN_CYCLES)) u_clkgen
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_hold(~combined_n),
      .i_tick(1'b1),
      .o_rst_n(clkgen_n)
   );

   rrs_delay_stage #(.COUNT(rrs_pkg::PERIP_SYS_CYCLES)) u_perip
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_hold(~clkgen_n),
      .i_tick(sys_tick),
      .o_rst_n(perip_n)
   );

   rrs_delay_stage #(.COUNT(rrs_pkg::CORE_SYS_CYCLES)) u_core
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_hold(~perip_n),
      .i_tick(sys_tick),
      .o_rst_n(core_n)
   );

   // Divider runs only once clock generation leaves reset
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         sys_phase_reg <= 1'b0;
      else if (!clkgen_n)
         sys_phase_reg <= 1'b0;
      else if (tick_2x)
         sys_phase_reg <= ~sys_phase_reg;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         clk3x_en_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         clk3x_en_reg <= (i_clock_source_select == rrs_pkg::SEL_PLL);
         done_reg <= core_n;
      end
   end

   // Observation counters: cycles since the power-on and combined holds released
   assign por_rel_cnt_next = !por_synced_n ? '0 :
                             (por_rel_cnt_reg == rrs_pkg::MON_MAX) ? por_rel_cnt_reg :
                             por_rel_cnt_reg + 1'b1;
   assign comb_rel_cnt_next = !combined_n ? '0 :
                              (comb_rel_cnt_reg == rrs_pkg::MON_MAX) ? comb_rel_cnt_reg :
                              comb_rel_cnt_reg + 1'b1;

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         por_rel_cnt_reg <= '0;
         comb_rel_cnt_reg <= '0;
      end
      else
      begin
         por_rel_cnt_reg <= por_rel_cnt_next;
         comb_rel_cnt_reg <= comb_rel_cnt_next;
      end
   end

   // No interrupt output exists on this block
   assign o_extended_por_rst_n = ext_por_n;
   assign o_combined_rst_n = combined_n;
   assign o_watchdog_logic_rst_n = swlogic_n;
   assign o_clkgen_rst_n = clkgen_n;
   assign o_perip_rst_n = perip_n;
   assign o_core_rst_n = core_n;
   assign o_test_access_rst_n = tap_sync_reg[1];
   assign o_sys_clk_div = sys_phase_reg;
   assign o_clk3x_enable = clk3x_en_reg;
   assign o_startup_done = done_reg;

   localparam logic [rrs_pkg::MON_W-1:0] EXT_MON = rrs_pkg::MON_W'(rrs_pkg::EXT_POR_CYCLES);
   localparam logic [rrs_pkg::MON_W-1:0] CG_MON = rrs_pkg::MON_W'(rrs_pkg::CLKGEN_CYCLES);
   localparam logic [rrs_pkg::MON_W-1:0] SW_MON = rrs_pkg::MON_W'(rrs_pkg::SWLOGIC_CYCLES);

   sequence s_perip_up;
      $rose(perip_n);
   endsequence

   sequence s_core_waits;
      !core_n [*2];
   endsequence

   chk_ext_por_release: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(ext_por_n) |-> (por_rel_cnt_reg == EXT_MON))
      else $error("stretched reset released at wrong count");

   chk_ext_por_source: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      ($past(ext_por_n) && por_synced_n) |-> ext_por_n)
      else $error("stretched reset asserted by a non power-on source");

   chk_clkgen_release: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(clkgen_n) |-> (comb_rel_cnt_reg == CG_MON))
      else $error("clock-generator reset released at wrong count");

   chk_swlogic_release: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(swlogic_n) |-> (comb_rel_cnt_reg == SW_MON))
      else $error("watchdog logic reset released at wrong count");

   chk_combined_holds: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !combined_n |-> (!clkgen_n && !perip_n && !core_n && !swlogic_n))
      else $error("stage out of reset while combined reset active");

   chk_core_after_perip: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_perip_up |-> s_core_waits)
      else $error("core reset released too soon after peripheral");

   chk_tap_por_only: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      ($past(tap_sync_reg[1]) && (!pin_synced_n || !por_synced_n || sync_sources))
         |-> o_test_access_rst_n)
      else $error("test access reset disturbed by a non power-on source");

   chk_sys_divide: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      ($past(clkgen_n) && clkgen_n && $past(tick_2x)) |-> (sys_phase_reg != $past(sys_phase_reg)))
      else $error("system clock divider did not toggle on 2x edge");

   chk_clk3x_off: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      ($past(i_clock_source_select) != rrs_pkg::SEL_PLL) |-> !o_clk3x_enable)
      else $error("3x clock enabled with master clock selected");

   chk_done_follows: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(core_n) |=> o_startup_done)
      else $error("startup done not flagged after core release");

   chk_recovery_asserts: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_partial_powerdown_recovery |-> (!ext_por_n && !combined_n))
      else $error("recovery reset did not assert stretched and combined resets");

   chk_sync_sources: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      sync_sources |-> (!o_combined_rst_n && !o_clkgen_rst_n && !o_watchdog_logic_rst_n))
      else $error("synchronous source did not hold the downstream resets");

   chk_divider_held: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !$past(clkgen_n) |-> !sys_phase_reg)
      else $error("system clock divider ran while clock generation in reset");

   chk_done_clears: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !core_n |=> !o_startup_done)
      else $error("startup done flagged while core held in reset");

endmodule

`default_nettype wire
